// *** uem_pkg.sv ***
// Package of constants and types for the EPROM mode controller
`default_nettype none
package uem_pkg;
   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned ADDR_W        = 13;
   localparam int unsigned DATA_W        = 8;
   // Read timing in ns (slowest grade), program timing in us
   localparam int unsigned ACCESS_NS     = 300;
   localparam int unsigned GATE_NS       = 120;
   localparam int unsigned FLOAT_NS      = 130;
   localparam int unsigned SETUP_US      = 2;
   localparam int unsigned PULSE_US      = 1000;
   localparam int unsigned ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned GATE_CYC      = (GATE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned FLOAT_CYC     = (FLOAT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SETUP_CYC     = SETUP_US * CLK_MHZ;
   localparam int unsigned PULSE_CYC     = PULSE_US * CLK_MHZ;
   localparam int unsigned CNT_W         = 24;
   // Signature address bits
   localparam int unsigned SIG_TRIG_BIT  = 9;
   localparam int unsigned SIG_SEL_BIT   = 0;
   // Command codes
   localparam logic [2:0]  CMD_READ      = 3'h0;
   localparam logic [2:0]  CMD_PROG      = 3'h1;
   localparam logic [2:0]  CMD_VERIFY    = 3'h2;
   localparam logic [2:0]  CMD_SIG       = 3'h3;
   localparam logic [2:0]  CMD_DISABLE   = 3'h4;
   typedef enum logic [6:0] {
      UEM_IDLE   = 7'h01,
      UEM_SETUP  = 7'h02,
      UEM_ACCESS = 7'h04,
      UEM_PULSE  = 7'h08,
      UEM_HOLD   = 7'h10,
      UEM_FLOAT  = 7'h20,
      UEM_DONE   = 7'h40
   } uem_state_t;
endpackage
`default_nettype wire

// *** uem_sync.sv ***
// Three-stage input synchroniser, change accepted when stages two and three agree
`default_nettype none
module uem_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         ref_clk_in,
   input  wire logic         reset_n_in,
   input  wire logic         clk_en_in,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else if (clk_en_in) begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule // uem_sync
`default_nettype wire

// *** uem_ctrl.sv ***
// Host controller that drives a UV EPROM through its pins in every mode
`default_nettype none
module uem_ctrl (
   input  wire logic                       ref_clk_in,
   input  wire logic                       reset_n_in,
   input  wire logic                       clk_en_in,
   // User side
   input  wire logic                       cmd_valid_in,
   input  wire logic [2:0]                 cmd_op_in,
   input  wire logic [uem_pkg::ADDR_W-1:0] cmd_addr_in,
   input  wire logic [uem_pkg::DATA_W-1:0] cmd_data_in,
   input  wire logic [1:0]                 cmd_dev_in,
   output logic                            cmd_ready_out,
   output logic                            rsp_valid_out,
   output logic [uem_pkg::DATA_W-1:0]      rsp_data_out,
   output logic [uem_pkg::DATA_W-1:0]      rsp_data2_out,
   output logic                            rsp_mismatch_out,
   // Device pins
   output logic [3:0]                      chip_select_n_out,
   output logic                            output_gate_n_out,
   output logic                            program_strobe_n_out,
   output logic                            program_supply_high_out,
   output logic                            signature_trigger_high_out,
   output logic [uem_pkg::ADDR_W-1:0]      addr_out,
   output logic [uem_pkg::DATA_W-1:0]      data_out,
   output logic                            data_oe_out,
   input  wire logic [uem_pkg::DATA_W-1:0] data_in
);
   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [uem_pkg::DATA_W-1:0] data_sync;

   uem_sync #(.W(uem_pkg::DATA_W)) uem_sync_inst (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (data_in),
      .sync_out   (data_sync)
   );

   // Sync latency of four cycles (three stages plus the agreement register) added to every sample point
   localparam int unsigned SYNC_CYC = 4;

   function automatic logic [uem_pkg::CNT_W-1:0] cyc(input int unsigned n);
      return uem_pkg::CNT_W'(n);
   endfunction

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   uem_pkg::uem_state_t         state;
   logic [uem_pkg::CNT_W-1:0]   cnt;
   logic [2:0]                  op;
   logic [1:0]                  dev;
   logic [uem_pkg::DATA_W-1:0]  wdata;
   logic                        sig_second;
   logic [uem_pkg::ADDR_W-1:0]  cmd_addr_hold;

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         state      <= uem_pkg::UEM_IDLE;
         cnt        <= '0;
         op         <= uem_pkg::CMD_READ;
         dev        <= 2'h0;
         wdata      <= 8'hff;
         sig_second <= 1'b0;
      end else if (clk_en_in) begin
         case (state)
            uem_pkg::UEM_IDLE: begin
               sig_second <= 1'b0;
               if (cmd_valid_in) begin
                  op    <= cmd_op_in;
                  dev   <= cmd_dev_in;
                  wdata <= cmd_data_in;
                  cnt   <= '0;
                  state <= uem_pkg::UEM_SETUP;
               end
            end
            uem_pkg::UEM_SETUP: begin
               // Address, supply and select settle before gate or strobe moves
               if (cnt >= cyc(uem_pkg::SETUP_CYC - 1)) begin
                  cnt   <= '0;
                  state <= (op == uem_pkg::CMD_PROG) ? uem_pkg::UEM_PULSE
                                                     : uem_pkg::UEM_ACCESS;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            uem_pkg::UEM_ACCESS: begin
               // Gate was lowered after select had been stable, so gate delay dominates
               if (cnt >= cyc(uem_pkg::ACCESS_CYC + SYNC_CYC)) begin
                  cnt <= '0;
                  if (op == uem_pkg::CMD_SIG && !sig_second) begin
                     sig_second <= 1'b1;
                  end else begin
                     state <= uem_pkg::UEM_FLOAT;
                  end
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            uem_pkg::UEM_PULSE: begin
               if (cnt >= cyc(uem_pkg::PULSE_CYC - 1)) begin
                  cnt   <= '0;
                  state <= uem_pkg::UEM_HOLD;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            uem_pkg::UEM_HOLD: begin
               // Data hold after strobe rises, then verify the byte
               if (cnt >= cyc(uem_pkg::SETUP_CYC - 1)) begin
                  cnt   <= '0;
                  op    <= uem_pkg::CMD_VERIFY;
                  state <= uem_pkg::UEM_ACCESS;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            uem_pkg::UEM_FLOAT: begin
               // Let the device outputs float before anything else drives
               if (cnt >= cyc(uem_pkg::FLOAT_CYC)) begin
                  cnt   <= '0;
                  state <= uem_pkg::UEM_DONE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            uem_pkg::UEM_DONE: begin
               state <= uem_pkg::UEM_IDLE;
            end
            default: begin
               state <= uem_pkg::UEM_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   logic busy;
   logic high_supply;
   logic gate_on;
   assign busy        = (state != uem_pkg::UEM_IDLE) && (state != uem_pkg::UEM_DONE);
   assign high_supply = busy && ((op == uem_pkg::CMD_PROG) || (op == uem_pkg::CMD_VERIFY));
   assign gate_on     = (state == uem_pkg::UEM_ACCESS) && (op != uem_pkg::CMD_DISABLE);

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         chip_select_n_out          <= 4'hf;
         output_gate_n_out          <= 1'b1;
         program_strobe_n_out       <= 1'b1;
         program_supply_high_out    <= 1'b0;
         signature_trigger_high_out <= 1'b0;
         addr_out                   <= '0;
         data_out                   <= '0;
         data_oe_out                <= 1'b0;
      end else if (clk_en_in) begin
         // One select per device; all others stay in standby or inhibit
         chip_select_n_out <= busy ? ~(4'h1 << dev) : 4'hf;
         output_gate_n_out <= ~gate_on;
         program_strobe_n_out <= !(state == uem_pkg::UEM_PULSE);
         program_supply_high_out <= high_supply;
         signature_trigger_high_out <= busy && (op == uem_pkg::CMD_SIG);
         if (op == uem_pkg::CMD_SIG) begin
            addr_out <= '0;
            addr_out[uem_pkg::SIG_TRIG_BIT] <= busy;
            addr_out[uem_pkg::SIG_SEL_BIT]  <= sig_second;
         end else begin
            addr_out <= cmd_addr_hold;
         end
         data_out    <= wdata;
         data_oe_out <= (op == uem_pkg::CMD_PROG) &&
                        ((state == uem_pkg::UEM_SETUP) || (state == uem_pkg::UEM_PULSE) ||
                         (state == uem_pkg::UEM_HOLD));
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         cmd_addr_hold <= '0;
      end else if (clk_en_in && state == uem_pkg::UEM_IDLE && cmd_valid_in) begin
         cmd_addr_hold <= cmd_addr_in;
      end
   end

   // ----------------------------------------------------------------
   // Response capture
   // ----------------------------------------------------------------
   logic sample;
   assign sample = (state == uem_pkg::UEM_ACCESS) &&
                   (cnt >= cyc(uem_pkg::ACCESS_CYC + SYNC_CYC));

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         cmd_ready_out    <= 1'b0;
         rsp_valid_out    <= 1'b0;
         rsp_data_out     <= '0;
         rsp_data2_out    <= '0;
         rsp_mismatch_out <= 1'b0;
      end else if (clk_en_in) begin
         cmd_ready_out <= (state == uem_pkg::UEM_IDLE) && !cmd_valid_in;
         rsp_valid_out <= (state == uem_pkg::UEM_FLOAT) && (cnt >= cyc(uem_pkg::FLOAT_CYC));
         if (sample) begin
            if (op == uem_pkg::CMD_SIG && sig_second) begin
               rsp_data2_out <= data_sync;
            end else begin
               rsp_data_out <= data_sync;
            end
            // Verify compares the whole byte: a 1 left as 0 cannot be repaired
            rsp_mismatch_out <= (op == uem_pkg::CMD_VERIFY) && (data_sync != wdata);
         end else if (state == uem_pkg::UEM_IDLE && cmd_valid_in) begin
            rsp_mismatch_out <= 1'b0;
         end
      end
   end
endmodule // uem_ctrl
`default_nettype wire

// *** uem_ctrl_properties.sv ***
// Pin-level checker for the EPROM mode controller
`default_nettype none
module uem_ctrl_chk (
   input wire logic        ref_clk_in,
   input wire logic        reset_n_in,
   input wire logic        rsp_valid_out,
   input wire logic [3:0]  chip_select_n_out,
   input wire logic        output_gate_n_out,
   input wire logic        program_strobe_n_out,
   input wire logic        program_supply_high_out,
   input wire logic        signature_trigger_high_out,
   input wire logic [12:0] addr_out,
   input wire logic [7:0]  data_out,
   input wire logic        data_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_LEAD = uem_pkg::ACCESS_CYC - uem_pkg::GATE_CYC;
   logic [15:0] sel_run;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   // ----------------------------------------
   // Select age
   // ----------------------------------------
   // Saturates so the long program pulse cannot wrap it
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in || &chip_select_n_out)
         sel_run <= 16'h0000;
      else if (sel_run != 16'hffff)
         sel_run <= sel_run + 16'h0001;
   end
   sequence s_gate_open;
      $fell(output_gate_n_out);
   endsequence
   AST_LEAD: assert property (s_gate_open |-> sel_run >= MIN_LEAD)
      else $error("gate opened too soon after select");
   AST_GATE_SEL: assert property (!output_gate_n_out |-> chip_select_n_out != 4'hf)
      else $error("gate low with no device selected");
   AST_ONE_SEL: assert property ($onehot0(~chip_select_n_out))
      else $error("more than one device selected");
   AST_PROG_COND: assert property (!program_strobe_n_out |-> program_supply_high_out
      && output_gate_n_out && chip_select_n_out != 4'hf) else $error("strobe outside program");
   AST_PROG_DATA: assert property (!program_strobe_n_out |-> data_oe_out)
      else $error("data not driven during pulse");
   AST_NO_FIGHT: assert property (data_oe_out |-> output_gate_n_out)
      else $error("host drives data while gate open");
   AST_PULSE_HOLD: assert property (!program_strobe_n_out && !$fell(program_strobe_n_out)
      |-> $stable(addr_out) && $stable(data_out)) else $error("address or data moved in pulse");
   AST_SIG_ADDR: assert property (signature_trigger_high_out
      |-> (addr_out & 13'h1dfe) == 13'h0000)
      else $error("other address lines high in signature");
   AST_SIG_READ: assert property (signature_trigger_high_out
      |-> !program_supply_high_out && program_strobe_n_out)
      else $error("signature with program levels");
   AST_DONE: assert property ($rose(output_gate_n_out) |-> ##[1:16] rsp_valid_out)
      else $error("no response after gate closed");
endmodule // uem_ctrl_chk
bind uem_ctrl uem_ctrl_chk uem_ctrl_chk_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
   .rsp_valid_out(rsp_valid_out), .chip_select_n_out(chip_select_n_out),
   .output_gate_n_out(output_gate_n_out), .program_strobe_n_out(program_strobe_n_out),
   .program_supply_high_out(program_supply_high_out), .addr_out(addr_out),
   .signature_trigger_high_out(signature_trigger_high_out), .data_out(data_out),
   .data_oe_out(data_oe_out));
`default_nettype wire

// *** uem_eprom_model.sv ***
// Behavioural model of one UV EPROM seen at its pins
`default_nettype none
module uem_eprom_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h5a, // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h3e  // Arbitrary value
) (
   input  wire logic        ref_clk_in,
   input  wire logic        chip_select_n_in,
   input  wire logic        output_gate_n_in,
   input  wire logic        program_strobe_n_in,
   input  wire logic        program_supply_high_in,
   input  wire logic        signature_trigger_high_in,
   input  wire logic [12:0] addr_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        data_oe_in,
   output logic [7:0]       dq_out,
   output logic             dq_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:8191];
   logic [7:0]  word;
   logic [7:0]  junk = 8'h00;
   int unsigned sel_age = 0;
   int unsigned gate_age = 0;
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(posedge ref_clk_in) begin
      sel_age <= chip_select_n_in ? 0 : sel_age + 1;
      gate_age <= (chip_select_n_in || output_gate_n_in) ? 0 : gate_age + 1;
      junk <= ~dq_out;
      // Bits only ever fall, so no pulse can bring a 1 back
      if (!chip_select_n_in && !program_strobe_n_in &&
          program_supply_high_in && data_oe_in)
         mem[addr_in] <= mem[addr_in] & data_in;
   end
   assign word = signature_trigger_high_in ? (addr_in[0] ? DEVICE_CODE : MAKER_CODE)
      : mem[addr_in];
   assign dq_oe_out = !chip_select_n_in && !output_gate_n_in &&
      program_strobe_n_in;
   // Until both delays have run the pins show junk, never stale data
   assign dq_out = (sel_age >= uem_pkg::ACCESS_CYC && gate_age >= uem_pkg::GATE_CYC)
      ? word : junk;
endmodule // uem_eprom_model
`default_nettype wire

// *** test_uv_eprom_mode_control.sv ***
// Self-checking bench of the EPROM controller driving two device models
`default_nettype none
module test_uv_eprom_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [12:0] ADDR_A = 13'h0a5c;
   logic        ref_clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        cmd_valid = 1'b0;
   logic [2:0]  cmd_op = 3'h0;
   logic [12:0] cmd_addr = 13'h0000;
   logic [7:0]  cmd_data = 8'h00;
   logic [1:0]  cmd_dev = 2'h0;
   logic        cmd_ready, rsp_valid, rsp_mismatch, gate_n, strobe_n;
   logic        vpp_hi, sig_hi, data_oe, drove;
   logic [3:0]  sel_n;
   logic [12:0] addr;
   logic [7:0]  rsp_data, rsp_data2, data_o, data_bus;
   logic [7:0]  m_q [2];
   logic [1:0]  m_oe;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;
   // Undriven bus shows the model's changing junk, never a held value
   assign data_bus = data_oe ? data_o : m_oe[0] ? m_q[0] : m_oe[1] ? m_q[1] : m_q[0];
   initial forever #10 ref_clk_in = ~ref_clk_in;
   uem_ctrl uem_ctrl_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
      .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .cmd_dev_in(cmd_dev), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data), .rsp_data2_out(rsp_data2), .rsp_mismatch_out(rsp_mismatch),
      .chip_select_n_out(sel_n), .output_gate_n_out(gate_n), .program_strobe_n_out(strobe_n),
      .program_supply_high_out(vpp_hi), .signature_trigger_high_out(sig_hi), .addr_out(addr),
      .data_out(data_o), .data_oe_out(data_oe), .data_in(data_bus));
   // Each device has its own select and its own data outputs; every other line is shared
   for (genvar i = 0; i < 2; i++) begin : g_dev
      uem_eprom_model uem_eprom_model_inst (.ref_clk_in(ref_clk_in), .chip_select_n_in(sel_n[i]),
         .output_gate_n_in(gate_n), .program_strobe_n_in(strobe_n),
         .program_supply_high_in(vpp_hi),
         .signature_trigger_high_in(sig_hi), .addr_in(addr), .data_in(data_o),
         .data_oe_in(data_oe), .dq_out(m_q[i]), .dq_oe_out(m_oe[i]));
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic run_cmd(input logic [2:0] op, input logic [1:0] dev, input logic [12:0] a,
                          input logic [7:0] d);
      int i;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 200) begin
         @(posedge ref_clk_in);
         i++;
      end
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_dev <= dev;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge ref_clk_in);
      cmd_valid <= 1'b0;
      drove = 1'b0;
      i = 0;
      while (rsp_valid !== 1'b1 && i < 60000) begin
         @(posedge ref_clk_in);
         drove |= |m_oe;
         i++;
      end
      chk("response", 8'h01, {7'h00, rsp_valid});
   endtask
   task automatic test_program();
      run_cmd(uem_pkg::CMD_PROG, 2'h1, ADDR_A, 8'h3c);
      chk("program readback", 8'h3c, rsp_data);
      chk("program mismatch", 8'h00, {7'h00, rsp_mismatch});
   endtask
   task automatic test_inhibit();
      run_cmd(uem_pkg::CMD_READ, 2'h0, ADDR_A, 8'h00);
      chk("unselected device", 8'hff, rsp_data);
      chk("read drove bus", 8'h01, {7'h00, drove});
      run_cmd(uem_pkg::CMD_READ, 2'h1, ADDR_A, 8'h00);
      chk("programmed byte", 8'h3c, rsp_data);
   endtask
   task automatic test_erased();
      run_cmd(uem_pkg::CMD_READ, 2'h1, ADDR_A + 13'h0001, 8'h00);
      chk("erased byte", 8'hff, rsp_data);
   endtask
   task automatic test_verify_bad();
      run_cmd(uem_pkg::CMD_VERIFY, 2'h1, ADDR_A, 8'h3d);
      chk("verify data", 8'h3c, rsp_data);
      chk("verify mismatch", 8'h01, {7'h00, rsp_mismatch});
   endtask
   task automatic test_signature();
      run_cmd(uem_pkg::CMD_SIG, 2'h0, 13'h0000, 8'h00);
      chk("maker code", 8'h5a, rsp_data);
      chk("device code", 8'h3e, rsp_data2);
   endtask
   task automatic test_disable();
      run_cmd(uem_pkg::CMD_DISABLE, 2'h0, ADDR_A, 8'h00);
      chk("disable drove bus", 8'h00, {7'h00, drove});
   endtask
   // Program pulse alone is 50000 cycles; the rest is small
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      test_program();
      test_inhibit();
      test_erased();
      test_verify_bad();
      test_signature();
      test_disable();
      final_report();
   end
endmodule // test_uv_eprom_mode_control
`default_nettype wire
